/* verilog/input_capture_control.sv */
// Input capture control: three channels, edge select, filter, event flags
// Function
// [R1] Per-channel enable bits at 6, 5, 4
// [R2] Hardware sets flag on selected edge
// [R3] Flag holds until software writes zero
// [R4] Select 00 fall, 01 rise, 10 either
// [R5] Software never programs reserved select 11
// [R6] Select fields at 5:4, 3:2, 1:0
// [R7] Filter enables at bits 6, 5, 4
// [R8] Disabled channel detects no edges
// [R9] Filter needs stable level several clocks
`timescale 1ns/10ps
module input_capture_control
    import input_capture_pkg::*;
(
    input  wire logic              clk_sys,  // System clock, 250 MHz
    input  wire logic              nrst,     // Async reset, active low
    input  wire logic [ADDR_W-1:0] regAddr,  // Register address
    input  wire logic              regWr,    // Write strobe
    input  wire logic              regRd,    // Read strobe
    input  wire logic [DATA_W-1:0] regWdata, // Write data
    output logic      [DATA_W-1:0] regRdata, // Read data, registered
    input  wire logic [2:0]        capPin,   // Capture inputs
    output logic      [2:0]        capEvent  // One-cycle edge pulses
);
    logic       rstMeta;       // Reset synchroniser first stage
    logic       rstSyncN;      // Synchronised reset
    logic [7:0] enableFlags;   // Enable and flag register
    logic [7:0] edgeSelect;    // Edge configuration register
    logic [7:0] filterEnable;  // Filter enable register
    logic [7:0] next_enableFlags;
    logic [7:0] next_edgeSelect;
    logic [7:0] next_filterEnable;
    logic [7:0] next_regRdata;
    logic [2:0] next_capEvent;
    logic [2:0] pinSync1;      // Input synchroniser first stage
    logic [2:0] pinSync2;      // Input synchroniser second stage
    logic [2:0] filtLevel;     // Filter outputs
    logic [2:0] chosenLevel;   // Filtered or direct level
    logic [2:0] prevLevel;     // Level seen last cycle
    logic [2:0] next_prevLevel;
    logic [2:0] edgeHit;       // Selected edge seen this cycle

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // Pins are nominally synchronous but external; two flops are cheap
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinSync1 <= '0;
            pinSync2 <= '0;
        end else begin
            pinSync1 <= capPin;
            pinSync2 <= pinSync1;
        end
    end

    // Per-channel filter and edge decode
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        // [R9] Stability filter
        capture_filter #(
            .STABLE_CYCLES (FILTER_CYCLES)
        ) u_filter (
            .clk_sys  (clk_sys),
            .rstSyncN (rstSyncN),
            .rawIn    (pinSync2[ch]),
            .filtOut  (filtLevel[ch])
        );

        logic       rise;   // Rising transition
        logic       fall;   // Falling transition
        edge_sel_t  sel;    // This channel's selection

        // [R7] Filter bypass select
        assign chosenLevel[ch] = filterEnable[FILTER_LSB + ch] ?
                                 filtLevel[ch] : pinSync2[ch];
        // [R8] Compare with previous sample
        assign rise = chosenLevel[ch] & ~prevLevel[ch];
        assign fall = ~chosenLevel[ch] & prevLevel[ch];
        // [R6] Field for this channel
        assign sel  = edge_sel_t'(edgeSelect[EDGE_W*ch +: EDGE_W]);

        // [R4] Edge decode; reserved code matches nothing
        always_comb begin
            case (sel)
                EDGE_FALL:   edgeHit[ch] = fall;
                EDGE_RISE:   edgeHit[ch] = rise;
                EDGE_EITHER: edgeHit[ch] = rise | fall;
                default:     edgeHit[ch] = 1'b0;
            endcase
        end
    end

    // Next state for registers, history and outputs
    always_comb begin
        next_enableFlags  = enableFlags;
        next_edgeSelect   = edgeSelect;
        next_filterEnable = filterEnable;
        next_prevLevel    = chosenLevel;
        next_capEvent     = '0;
        next_regRdata     = regRdata;
        // Software writes first, hardware sets after, so a set wins
        if (regWr) begin
            case (regAddr)
                // [R1] Enable bits and flag clears
                OFS_ENABLE_FLAGS:
                    next_enableFlags = regWdata & MASK_ENABLE_FLAGS;
                OFS_EDGE_SELECT:
                    next_edgeSelect = regWdata & MASK_EDGE_SELECT;
                OFS_FILTER_ENABLE:
                    next_filterEnable = regWdata & MASK_FILTER_ENABLE;
                default: ;
            endcase
        end
        for (int ch = 0; ch < NUM_CHAN; ch++) begin
            // [R8] Only enabled channels see edges
            if (enableFlags[ON_LSB + ch] && edgeHit[ch]) begin
                // [R2] Set sticky flag; [R3] only software clears
                next_enableFlags[FLAG_LSB + ch] = 1'b1;
                next_capEvent[ch] = 1'b1;
            end
        end
        // Read data captured on the strobe; unmapped reads zero
        if (regRd) begin
            case (regAddr)
                OFS_ENABLE_FLAGS:  next_regRdata = enableFlags;
                OFS_EDGE_SELECT:   next_regRdata = edgeSelect;
                OFS_FILTER_ENABLE: next_regRdata = filterEnable;
                default:           next_regRdata = 8'h00;
            endcase
        end
    end

    // Register all control state and outputs
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            enableFlags  <= RST_ENABLE_FLAGS;
            edgeSelect   <= RST_EDGE_SELECT;
            filterEnable <= RST_FILTER_ENABLE;
            prevLevel    <= '0;
            capEvent     <= '0;
            regRdata     <= 8'h00;
        end else begin
            enableFlags  <= next_enableFlags;
            edgeSelect   <= next_edgeSelect;
            filterEnable <= next_filterEnable;
            prevLevel    <= next_prevLevel;
            capEvent     <= next_capEvent;
            regRdata     <= next_regRdata;
        end
    end
endmodule : input_capture_control

/* verilog/input_capture_pkg.sv */
// Package: register offsets, field positions and filter timing for capture
package input_capture_pkg;
    // Register bus address and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CHAN = 3;
    // Register offsets in the special-function space
    localparam logic [7:0] OFS_ENABLE_FLAGS  = 8'h92;
    localparam logic [7:0] OFS_EDGE_SELECT   = 8'h93;
    localparam logic [7:0] OFS_FILTER_ENABLE = 8'h94;
    // Reset values
    localparam logic [7:0] RST_ENABLE_FLAGS  = 8'h00;
    localparam logic [7:0] RST_EDGE_SELECT   = 8'h00;
    localparam logic [7:0] RST_FILTER_ENABLE = 8'h00;
    // Field positions: channel n enable at ON_LSB+n, flag at FLAG_LSB+n
    localparam int ON_LSB     = 4;
    localparam int FLAG_LSB   = 0;
    localparam int FILTER_LSB = 4;
    localparam int EDGE_W     = 2;
    // Writable bit masks, reserved bits read zero
    localparam logic [7:0] MASK_ENABLE_FLAGS  = 8'h77;
    localparam logic [7:0] MASK_EDGE_SELECT   = 8'h3f;
    localparam logic [7:0] MASK_FILTER_ENABLE = 8'h70;
    // Edge-select encodings; 2'h3 is reserved
    typedef enum logic [1:0] {
        EDGE_FALL   = 2'b00,
        EDGE_RISE   = 2'b01,
        EDGE_EITHER = 2'b10,
        EDGE_RSVD   = 2'b11
    } edge_sel_t;
    // Filter: level must stand this long before it is taken
    localparam int FILTER_NS       = 16;
    localparam int CLK_PERIOD_NS   = 4;
    localparam int FILTER_CYCLES   =
        (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_CNT_W    = 3;
endpackage : input_capture_pkg

/* verilog/capture_filter.sv */
// Stability filter for one capture input
`timescale 1ns/10ps
module capture_filter
    import input_capture_pkg::*;
#(
    parameter int STABLE_CYCLES = FILTER_CYCLES // Cycles a level must hold
) (
    input  wire logic clk_sys,   // System clock
    input  wire logic rstSyncN,  // Synchronised reset, active low
    input  wire logic rawIn,     // Synchronised input level
    output logic      filtOut    // Filtered level
);
    // Counter must be able to reach the target
    initial begin
        if (STABLE_CYCLES < 1 || STABLE_CYCLES >= (1 << FILTER_CNT_W))
            $error("capture_filter: STABLE_CYCLES out of range");
    end

    localparam logic [FILTER_CNT_W-1:0] TARGET =
        FILTER_CNT_W'(STABLE_CYCLES);

    logic [FILTER_CNT_W-1:0] stableCnt;      // Cycles input differed
    logic [FILTER_CNT_W-1:0] next_stableCnt; // Next count
    logic                    next_filtOut;   // Next filtered level

    // Count how long the input disagrees with the accepted level
    always_comb begin
        next_filtOut   = filtOut;
        next_stableCnt = '0;
        if (rawIn != filtOut) begin
            // A glitch shorter than the window restarts the count
            if (stableCnt == TARGET - FILTER_CNT_W'(1)) begin
                next_filtOut = rawIn;
            end else begin
                next_stableCnt = stableCnt + FILTER_CNT_W'(1);
            end
        end
    end

    // Register filter state
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stableCnt <= '0;
            filtOut   <= 1'b0;
        end else begin
            stableCnt <= next_stableCnt;
            filtOut   <= next_filtOut;
        end
    end
endmodule : capture_filter

/* dv/input_capture_checker.sv */
// Checker: port-level relations of the capture control block
`timescale 1ns/10ps
module input_capture_checker
    import input_capture_pkg::*;
(
    input wire logic              clk_sys,  // Clock
    input wire logic              nrst,     // Reset, active low
    input wire logic [ADDR_W-1:0] regAddr,  // Address
    input wire logic              regWr,    // Write strobe
    input wire logic              regRd,    // Read strobe
    input wire logic [DATA_W-1:0] regWdata, // Write data
    input wire logic [DATA_W-1:0] regRdata, // Read data
    input wire logic [2:0]        capPin,   // Pins
    input wire logic [2:0]        capEvent  // Edge pulses
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic rdFlags = regRd && regAddr == OFS_ENABLE_FLAGS; // Flag read
    a_enable_field: assert property (regWr && regAddr == 8'h92
        ##1 rdFlags |=> regRdata[6:4] == $past(regWdata[6:4], 2))
        else $error("enable bits lost");
    a_flag_seen: assert property ((|capEvent) ##1 rdFlags
        |=> (regRdata[2:0] & $past(capEvent, 2)) == $past(capEvent, 2))
        else $error("event without flag");
    // Two reads in a row without a write may only keep or gain flags
    a_flag_sticky: assert property (rdFlags && !regWr ##1 rdFlags
        |=> (regRdata[2:0] & $past(regRdata[2:0])) == $past(regRdata[2:0]))
        else $error("flag dropped by hardware");
    a_edge_field: assert property (regWr && regAddr == 8'h93
        ##1 regRd && regAddr == 8'h93
        |=> regRdata == ($past(regWdata, 2) & MASK_EDGE_SELECT))
        else $error("edge field wrong");
    a_filter_field: assert property (regWr && regAddr == 8'h94
        ##1 regRd && regAddr == 8'h94
        |=> regRdata == ($past(regWdata, 2) & MASK_FILTER_ENABLE))
        else $error("filter field wrong");
    // Longest path is sync plus filter, seven clocks
    a_quiet_pins: assert property ($stable(capPin) [*8]
        |-> capEvent == 3'h0) else $error("event on quiet pins");
    a_unmapped_zero: assert property (regRd && (regAddr < 8'h92
        || regAddr > 8'h94) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_data_holds: assert property (!regRd |=> $stable(regRdata))
        else $error("read data moved");
endmodule : input_capture_checker

/* dv/capture_pin_source.sv */
// Model of the external signals on the capture pins
`timescale 1ns/10ps
module capture_pin_source (
    input  wire logic       clk_sys, // Clock the levels follow
    output logic      [2:0] capPin   // Push-pull levels, never released
);
    initial capPin = 3'h0;
    // Hold a level for n clocks; changes land just after an edge
    task automatic drive(input logic [2:0] lvl, input int n);
        capPin <= lvl;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : drive
endmodule : capture_pin_source

/* dv/input_capture_control_bench.sv */
// Bench: register sequences and pin stimulus for capture control
`timescale 1ns/10ps
module input_capture_control_bench;
    import input_capture_pkg::*;
    logic clk_sys, nrst, regWr, regRd;           // Clock, reset, strobes
    logic [7:0] regAddr, regWdata, regRdata;     // Register bus
    logic [2:0] capPin, capEvent;                // Pins and pulses
    int err_total, total_checks, cycles;         // Counters
    input_capture_control i_input_capture_control (.clk_sys(clk_sys),
        .nrst(nrst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
        .regWdata(regWdata), .regRdata(regRdata), .capPin(capPin),
        .capEvent(capEvent));
    capture_pin_source i_capture_pin_source (.clk_sys(clk_sys),
        .capPin(capPin));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Cut a hung run short
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Two reads in a row, idle cycle, then the held data is compared
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        regRd <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(regRdata, exp);
    endtask : rd
    task automatic wrrd(input logic [7:0] a, d, exp);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        #1;
        regWr <= 1'b0;
        rd(a, exp);
    endtask : wrrd
    task automatic end_of_test;
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    initial begin
        {nrst, regWr, regRd, regAddr, regWdata} = '0;
        {err_total, total_checks, cycles} = '0;
        repeat (16) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        // Reset values, with an unmapped place on each side
        for (int a = 8'h91; a <= 8'h95; a++) begin
            rd(8'(a), 8'h00);
        end
        wrrd(OFS_EDGE_SELECT, 8'hc6, 8'h06);
        wrrd(OFS_FILTER_ENABLE, 8'h8f, 8'h00);
        // Each legal code on all channels; code 11 is never written
        for (int m = 0; m < 3; m++) begin
            wrrd(8'h93, {2'b00, {3{2'(m)}}}, {2'b00, {3{2'(m)}}});
            wrrd(OFS_ENABLE_FLAGS, 8'h70, 8'h70);
            // Unfiltered pulse stands in the third cycle after the change
            i_capture_pin_source.drive(3'h7, 3);
            chk({5'h0, capEvent}, (m != 0) ? 8'h07 : 8'h00);
            rd(OFS_ENABLE_FLAGS, (m != 0) ? 8'h77 : 8'h70);
            i_capture_pin_source.drive(3'h0, 10);
            // Fall sets the flags for code 00, rise flags stay set for 01 and 10, so every code ends at 0x77
            rd(OFS_ENABLE_FLAGS, 8'h77);
        end
        // Channel 2 off, channel 1 filtered, short glitch then long pulse
        wrrd(OFS_FILTER_ENABLE, 8'h20, 8'h20);
        wrrd(OFS_ENABLE_FLAGS, 8'h30, 8'h30);
        i_capture_pin_source.drive(3'h7, FILTER_CYCLES - 1);
        i_capture_pin_source.drive(3'h0, 12);
        rd(OFS_ENABLE_FLAGS, 8'h31);
        i_capture_pin_source.drive(3'h7, 12);
        rd(OFS_ENABLE_FLAGS, 8'h33);
        wrrd(OFS_ENABLE_FLAGS, 8'h00, 8'h00);
        i_capture_pin_source.drive(3'h0, 12);
        rd(OFS_ENABLE_FLAGS, 8'h00);
        end_of_test();
    end
endmodule : input_capture_control_bench
bind input_capture_control input_capture_checker i_input_capture_checker (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
    .capPin(capPin), .capEvent(capEvent));
